// ---- rtl/qet_tracker.sv ----
/*
 quadrature encoder tracker top: filter, speed mode selector, edge counter
 and 32-bit position. assumes an encoder with two phases on plain pins
 and direction given by the motor drive logic.
*/
`timescale 1ns/1ps
`default_nettype none
module qet_tracker
#(
    parameter int UPDATE_CYCLES = qet_pkg::UPDATE_CYCLES
)
(
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        phase_a,
    input  wire logic        phase_b,
    input  wire logic        direction_fwd,
    output logic             mode_bit_low,
    output logic             mode_bit_high,
    output logic      [31:0] position,
    output logic      [15:0] edge_count,
    output logic             update_pulse,
    output logic             capture_pulse,
    output logic             capture_rising,
    output logic      [7:0]  port1_status
);
    logic [1:0]        phase_filt;
    logic              cnt_evt;
    logic [1:0]        frise;
    logic [1:0]        ffall;
    qet_pkg::qet_mode_e mode_r;
    qet_pkg::qet_mode_e mode_nxt;
    logic [31:0]       tick_r;
    logic [15:0]       cnt_r;
    logic [15:0]       cnt_old_r;
    logic [31:0]       pos_r;
    logic [31:0]       pos_nxt;
    logic [31:0]       diff;
    logic [15:0]       diff16;
    logic              tick_hit;
    logic              cap_a;
    logic              cap_any;
    logic              cap_evt;
    logic              cap_r;
    logic              cap_rise_r;
    logic              upd_r;
    logic [2:0]        sec;
    wire logic [1:0]   cap_hit;
    logic              cap_rise;

    qet_edge_filter u_filt
    (
        .ref_clk           (ref_clk),
        .rstn              (rstn),
        .phase_raw         ({phase_b, phase_a}),
        .phase_filt        (phase_filt),
        .count_clock_input (cnt_evt),
        .filt_rise         (frise),
        .filt_fall         (ffall)
    );

    // periodic update strobe, one cycle in every UPDATE_CYCLES
    assign tick_hit = (tick_r == 32'(UPDATE_CYCLES - 1));
    // modular 16-bit subtraction stays right across a counter wrap
    assign diff16   = cnt_r - cnt_old_r;
    assign diff     = {16'h0000, diff16};
    // position accumulates with silent wrap
    assign pos_nxt  = direction_fwd ? pos_r + diff
                                    : pos_r - diff;

    always_comb
    begin
        mode_nxt = mode_r;
        if (tick_hit)
        begin
            case (mode_r)
                qet_pkg::QET_MODE2:
                    if (diff <= qet_pkg::MODE1_MAX_DIFF)
                        mode_nxt = qet_pkg::QET_MODE1;
                qet_pkg::QET_MODE1:
                    if (diff < qet_pkg::MODE0_MIN_DIFF)
                        mode_nxt = qet_pkg::QET_MODE0;
                    else if (diff >= qet_pkg::MODE2_MIN_DIFF)
                        mode_nxt = qet_pkg::QET_MODE2;
                qet_pkg::QET_MODE0:
                    // speed-up path; slow to fast ordering
                    if (diff >= qet_pkg::MODE0_MIN_DIFF)
                        mode_nxt = qet_pkg::QET_MODE1;
                default:
                    mode_nxt = qet_pkg::QET_MODE0;
            endcase
        end
    end

    // mode 1: two capture channels watch phase a, one per edge polarity
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_cap
        if (ch == 0)
        begin : g_rise
            assign cap_hit[ch] = frise[0];
        end
        else
        begin : g_fall
            assign cap_hit[ch] = ffall[0];
        end
    end

    assign cap_a    = |cap_hit;
    assign cap_any  = cap_a | frise[1] | ffall[1];
    // decode on the mode about to be shown, so capture_pulse and the mode
    // bits always agree; an edge in the switching cycle follows the new
    // mode
    assign cap_evt  = (mode_nxt == qet_pkg::QET_MODE1) ? cap_a
                    : (mode_nxt == qet_pkg::QET_MODE0) ? cap_any
                    : 1'b0;
    assign cap_rise = (mode_nxt == qet_pkg::QET_MODE1) ? cap_hit[0]
                    : (frise[0] | frise[1]);

    assign sec = tick_hit ? qet_pkg::SEC_UPDATE
               : cap_evt  ? qet_pkg::SEC_CAPTURE
               : (mode_nxt == qet_pkg::QET_MODE2 && cnt_evt)
                          ? qet_pkg::SEC_COUNT
                          : qet_pkg::SEC_IDLE;

    // update period counter
    always_ff @(posedge ref_clk)
    begin
        if (!rstn || tick_hit)
        begin
            tick_r <= 32'h0000_0000;
        end
        else
        begin
            tick_r <= tick_r + 32'h0000_0001;
        end
    end

    // counter counts every filtered edge; only mode 2 relies on it alone
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            cnt_r <= 16'h0000;
        end
        else if (cnt_evt)
        begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    // snapshot and position fold once per period
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            cnt_old_r <= 16'h0000;
            pos_r     <= qet_pkg::POS_RESET;
        end
        else if (tick_hit)
        begin
            cnt_old_r <= cnt_r;
            pos_r     <= pos_nxt;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            mode_r <= qet_pkg::QET_MODE0;
        end
        else
        begin
            mode_r <= mode_nxt;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            cap_r      <= 1'b0;
            cap_rise_r <= 1'b0;
            upd_r      <= 1'b0;
        end
        else
        begin
            cap_r      <= cap_evt;
            cap_rise_r <= cap_evt & cap_rise;
            upd_r      <= tick_hit;
        end
    end

    // debug view: mode in bits 1:0, section above; registered so that
    // the mode bits leave the block straight from flip-flops
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            port1_status <= 8'h00;
        end
        else
        begin
            port1_status <= {3'h0, sec, mode_nxt == qet_pkg::QET_MODE2,
                             mode_nxt == qet_pkg::QET_MODE1};
        end
    end

    // mode bits straight from the port1_status flip-flops, not from mode_r
    assign mode_bit_low   = port1_status[0];
    assign mode_bit_high  = port1_status[1];
    assign position       = pos_r;
    assign edge_count     = cnt_r;
    assign update_pulse   = upd_r;
    assign capture_pulse  = cap_r;
    assign capture_rising = cap_rise_r;
endmodule
`default_nettype wire

// ---- pkg/qet_pkg.sv ----
/*
 package for the quadrature encoder tracker: modes, timing and thresholds.
 assumes a 250 MHz ref_clk.
*/
`default_nettype none
package qet_pkg;
    typedef enum logic [1:0] {QET_MODE0, QET_MODE1, QET_MODE2} qet_mode_e;
    localparam int          CLK_MHZ        = 250;
    localparam int          UPDATE_US      = 260;
    localparam int          UPDATE_CYCLES  = UPDATE_US * CLK_MHZ;
    localparam logic [31:0] MODE1_MAX_DIFF = 32'h0000_0005;
    localparam logic [31:0] MODE0_MIN_DIFF = 32'h0000_0002;
    localparam logic [31:0] MODE2_MIN_DIFF = 32'h0000_0019;
    localparam logic [31:0] POS_RESET      = 32'h0000_0000;
    localparam logic [2:0]  SEC_IDLE       = 3'h0;
    localparam logic [2:0]  SEC_CAPTURE    = 3'h1;
    localparam logic [2:0]  SEC_UPDATE     = 3'h2;
    localparam logic [2:0]  SEC_COUNT      = 3'h4;
endpackage
`default_nettype wire

// ---- rtl/qet_edge_filter.sv ----
/*
 edge filter: synchronises both encoder phases, makes one-shot pulses on
 every edge, and latches each phase only on edges of the opposite phase.
 assumes raw phase pins are asynchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module qet_edge_filter
(
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic [1:0] phase_raw,
    output logic      [1:0] phase_filt,
    output logic            count_clock_input,
    output logic      [1:0] filt_rise,
    output logic      [1:0] filt_fall
);
    logic [1:0] s1_r;
    logic [1:0] s2_r;
    logic [1:0] s3_r;
    logic [1:0] stable_r;
    logic [1:0] filt_r;
    logic [1:0] filt_d_r;
    logic [1:0] chg;
    logic [1:0] oneshot;
    logic [1:0] filt_nxt;

    // a change counts once the second and third stage agree
    assign chg     = (s2_r ~^ s3_r) & (s2_r ^ stable_r);
    // xor one-shot on each stable phase
    assign oneshot = chg;
    // a pulse on one phase latches the other phase
    assign filt_nxt[0] = oneshot[1] ? s3_r[0] : filt_r[0];
    assign filt_nxt[1] = oneshot[0] ? s3_r[1] : filt_r[1];
    // a repeated edge on one phase never reaches filt_r

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            s1_r     <= 2'h0;
            s2_r     <= 2'h0;
            s3_r     <= 2'h0;
            stable_r <= 2'h0;
            filt_r   <= 2'h0;
            filt_d_r <= 2'h0;
        end
        else
        begin
            s1_r     <= phase_raw;
            s2_r     <= s1_r;
            s3_r     <= s2_r;
            stable_r <= stable_r ^ chg;
            filt_r   <= filt_nxt;
            filt_d_r <= filt_r;
        end
    end

    assign phase_filt        = filt_d_r;
    // count event on both edges of both filtered phases
    assign count_clock_input = |(filt_r ^ filt_d_r);
    assign filt_rise         = filt_r & ~filt_d_r;
    assign filt_fall         = ~filt_r & filt_d_r;
endmodule
`default_nettype wire

// ---- dv/qet_tracker_asserts.sv ----
/*
 checker for the tracker: update timing, mode bits, counter steps.
 assumes binding to qet_tracker, sharing its UPDATE_CYCLES.
*/
`timescale 1ns/1ps
`default_nettype none
module qet_tracker_asserts
#(
    parameter int UPDATE_CYCLES = 65000
)
(
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        mode_bit_low,
    input wire logic        mode_bit_high,
    input wire logic [31:0] position,
    input wire logic [15:0] edge_count,
    input wire logic        update_pulse,
    input wire logic        capture_pulse,
    input wire logic        capture_rising,
    input wire logic [7:0]  port1_status
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    int   gap_r;
    logic seen_r;
    // the first period after reset is not timed, its phase is free
    always_ff @(posedge ref_clk)
    begin
        gap_r  <= (!rstn || update_pulse) ? 0 : gap_r + 1;
        seen_r <= rstn && (seen_r || update_pulse);
    end
    sequence s_single;
        update_pulse ##1 !update_pulse;
    endsequence
    chk_update_period: assert property (update_pulse && seen_r |->
        gap_r == UPDATE_CYCLES - 1) else $error("update period wrong");
    chk_update_single: assert property (update_pulse |-> s_single)
        else $error("update pulse too long");
    chk_pos_at_update: assert property ($changed(position)
        |-> update_pulse) else $error("position moved between updates");
    chk_mode_at_update: assert property ($changed({mode_bit_high,
        mode_bit_low}) |-> update_pulse) else $error("mode moved early");
    chk_mode2_entry: assert property ($rose(mode_bit_high)
        |-> $past(mode_bit_low)) else $error("mode 2 not from mode 1");
    chk_mode2_nocap: assert property (mode_bit_high
        |-> !capture_pulse) else $error("capture seen in mode 2");
    chk_count_step: assert property ($changed(edge_count) |->
        edge_count == $past(edge_count) + 16'h0001)
        else $error("edge count jumped");
    chk_port1_update: assert property (port1_status[3]
        == update_pulse) else $error("port1 update section wrong");
    chk_cap_section: assert property (port1_status[2]
        |-> capture_pulse) else $error("capture section without pulse");
    chk_count_section: assert property (port1_status[4]
        |-> mode_bit_high) else $error("count section outside mode 2");
    chk_rise_has_cap: assert property (capture_rising
        |-> capture_pulse) else $error("rising flag without capture");
    chk_port1_section: assert property ($onehot0(port1_status[4:2]))
        else $error("port1 section not one-hot");
endmodule
bind qet_tracker qet_tracker_asserts #(.UPDATE_CYCLES(UPDATE_CYCLES)) u_chk
(
    .ref_clk(ref_clk), .rstn(rstn), .mode_bit_low(mode_bit_low),
    .mode_bit_high(mode_bit_high), .position(position),
    .edge_count(edge_count), .update_pulse(update_pulse),
    .capture_pulse(capture_pulse), .capture_rising(capture_rising),
    .port1_status(port1_status)
);
`default_nettype wire

// ---- dv/qet_encoder_model.sv ----
/*
 encoder model: two phases in quadrature, one step every gap cycles.
 assumes gap is 0 (stopped) or at least 4, so each level holds long enough.
*/
`timescale 1ns/1ps
`default_nettype none
module qet_encoder_model
(
    input  wire logic        ref_clk,
    input  wire logic [15:0] gap,
    input  wire logic        fwd,
    input  wire logic        wobble,
    output logic             phase_a,
    output logic             phase_b,
    output logic      [15:0] steps
);
    logic [15:0] tick_r = 16'h0000;
    wire logic   step   = gap != 16'h0000 && tick_r == gap - 16'h0001;
    // wobble shakes phase a alone, as a stopped shaft vibrating would
    wire logic   flip_a = wobble || ((phase_a == phase_b) == fwd);
    initial
    begin
        phase_a = 1'b0;
        phase_b = 1'b0;
        steps   = 16'h0000;
    end
    always @(posedge ref_clk)
    begin
        tick_r <= (step || gap == 16'h0000) ? 16'h0000 : tick_r + 16'h0001;
        if (step)
        begin
            phase_a <= flip_a ? !phase_a : phase_a;
            phase_b <= flip_a ? phase_b : !phase_b;
            steps   <= steps + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ---- dv/test_qet_tracker.sv ----
/*
 bench for the tracker: steps the encoder model, checks counts, mode
 and position. assumes model and checker are compiled beforehand.
*/
`timescale 1ns/1ps
`default_nettype none
module test_qet_tracker;
    logic        ref_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic        dir_fwd = 1'b1;
    logic        fwd     = 1'b1;
    logic        wobble  = 1'b0;
    logic [15:0] gap     = 16'h0000;
    logic [31:0] c0;
    wire  logic  pa, pb, ml, mh, upd;
    wire  logic [31:0] pos;
    wire  logic [15:0] cnt, steps;
    int          fails = 0;
    int          compares = 0;
    int          cyc = 0;
    always #2 ref_clk = ~ref_clk;
    qet_tracker #(.UPDATE_CYCLES(200)) u_dut (.ref_clk(ref_clk),
        .rstn(rstn), .phase_a(pa), .phase_b(pb), .direction_fwd(dir_fwd),
        .mode_bit_low(ml), .mode_bit_high(mh), .position(pos),
        .edge_count(cnt), .update_pulse(upd), .capture_pulse(),
        .capture_rising(), .port1_status());
    qet_encoder_model u_enc (.ref_clk(ref_clk), .gap(gap), .fwd(fwd),
        .wobble(wobble), .phase_a(pa), .phase_b(pb), .steps(steps));
    task automatic stop_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            stop_test();
        end
    end
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        compares++;
        if (exp !== got)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic run(input logic [15:0] g, input logic [15:0] n,
                       input logic w, input logic f);
        logic [15:0] s;
        s = steps;
        @(posedge ref_clk);
        gap <= g;
        wobble <= w;
        fwd <= f;
        dir_fwd <= f;
        do @(negedge ref_clk); while (steps != s + n);
        @(posedge ref_clk);
        gap <= 16'h0000;
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic wait_upd();
        do @(negedge ref_clk); while (upd !== 1'b1);
    endtask
    initial
    begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        @(negedge ref_clk);
        check("position", 32'h0, pos);
        check("mode", 32'h0, {mh, ml});
        run(16'h0014, 16'h0002, 1'b0, 1'b1);
        c0 = cnt;
        run(16'h0014, 16'h0014, 1'b0, 1'b1);
        check("edge_count", c0 + 32'h14, cnt);
        run(16'h0014, 16'h0004, 1'b1, 1'b1);
        c0 = cnt;
        run(16'h0014, 16'h0004, 1'b1, 1'b1);
        check("edge_count", c0, cnt);
        // start the fast run just after an update so period edges are known
        wait_upd();
        run(16'h0004, 16'h00C8, 1'b0, 1'b1);
        check("mode_bit_high", 32'h1, mh);
        wait_upd();
        check("position", 32'hDD, pos);
        check("edge_count", 32'hDD, cnt);
        check("mode", 32'h1, {mh, ml});
        wait_upd();
        check("mode", 32'h0, {mh, ml});
        run(16'h0004, 16'h0028, 1'b0, 1'b0);
        wait_upd();
        wait_upd();
        check("position", 32'hB7, pos);
        check("edge_count", 32'h103, cnt);
        stop_test();
    end
endmodule
`default_nettype wire
